// ==== logic/embsp_defs.vh ====
// Constants for the external memory bus sequencer
`ifndef EMBSP_DEFS_VH
`define EMBSP_DEFS_VH

// Register indexes; byte address is index times four
`define EMBSP_RI_BTC      10'h08E
`define EMBSP_RI_AC       10'h090
`define EMBSP_RI_TA       10'h091
`define EMBSP_RI_ST       10'h092

// Register fields and reset values
`define EMBSP_BTC_STR     2:0
`define EMBSP_AC_PGEN     7
`define EMBSP_AC_PGSEL    1:0
`define EMBSP_BTC_RST     8'h01
`define EMBSP_AC_RST      8'h00

// Timed access keys and window length in clocks
`define EMBSP_TA_KEY1     8'hAA
`define EMBSP_TA_KEY2     8'h55
`define EMBSP_TA_WIN      4'h8
`define EMBSP_TA_IDLE     2'h0
`define EMBSP_TA_ARMED    2'h1
`define EMBSP_TA_OPEN     2'h2

// Request kinds
`define EMBSP_K_FETCH     2'h0
`define EMBSP_K_RD        2'h1
`define EMBSP_K_WR        2'h2

// Page select codes
`define EMBSP_PS_1CYC     2'h0
`define EMBSP_PS_2CYC     2'h1
`define EMBSP_PS_4CYC     2'h2
`define EMBSP_PS_MODE2    2'h3

// Bus structures
`define EMBSP_BS_NP       2'h0
`define EMBSP_BS_PM1      2'h1
`define EMBSP_BS_PM2      2'h2

// Phase lengths in system clocks
`define EMBSP_NP_ALE      6'h01
`define EMBSP_NP_SET0     6'h01
`define EMBSP_NP_STB0     6'h02
`define EMBSP_NP_SET1     6'h02
`define EMBSP_NP_HLD1     6'h01
`define EMBSP_LONG_ALE    6'h05
`define EMBSP_LONG_SET    6'h06
`define EMBSP_LONG_HLD    6'h05
`define EMBSP_LONG_MIN    4'h7
`define EMBSP_LONG_BASE   4'h3
`define EMBSP_STR_CLKS    6'h04
`define EMBSP_ZERO_LEN    6'h00
`define EMBSP_ONE_LEN     6'h01
`define EMBSP_HIT_PS0     6'h01
`define EMBSP_HIT_PS1     6'h02
`define EMBSP_HIT_PS2     6'h04
`define EMBSP_HIT_M2      6'h02
`define EMBSP_HSTB_PS0    6'h01
`define EMBSP_HSTB_PS1    6'h01
`define EMBSP_HSTB_PS2    6'h02
`define EMBSP_HSTB_M2     6'h01

`endif

// ==== logic/embsp_page_det.v ====
// Page address store and page hit or miss decision
`include "embsp_defs.vh"

module embsp_page_det (
    input  wire       ref_clk,
    input  wire       rstn,
    input  wire       ce,
    input  wire       pg_en,
    input  wire [1:0] pg_sel,
    input  wire       take,
    input  wire       is_data,
    input  wire [7:0] addr_hi,
    output wire       miss,
    output wire       page_valid,
    output wire [7:0] last_page
);

    reg       valid_q;
    reg [7:0] page_q;
    reg       force_q;
    reg [2:0] mode_q;

    wire mode_chg = (mode_q != {pg_en, pg_sel});
    wire sel_one  = (pg_sel == `EMBSP_PS_1CYC);

    assign miss = !valid_q || mode_chg || (addr_hi != page_q) || (sel_one && (is_data || force_q));

    assign page_valid = valid_q;
    assign last_page  = page_q;

    always @(posedge ref_clk) begin
        if (!rstn) begin
            valid_q <= 1'b0;
            page_q  <= 8'h00;
            force_q <= 1'b0;
            mode_q  <= 3'h0;
        end else if (ce) begin
            mode_q <= {pg_en, pg_sel};
            if (mode_chg) begin
                valid_q <= 1'b0;
                force_q <= 1'b0;
            end
            if (take) begin
                valid_q <= 1'b1;
                page_q  <= addr_hi;
                force_q <= sel_one && is_data;
            end
        end
    end

endmodule // embsp_page_det

// ==== logic/embsp_top.v ====
// External memory bus sequencer with data stretch and page modes
//
// Operation
// - Internal one clock, external four clocks
// - Stretch from timing register low bits
// - Each stretch cycle is four clocks
// - Codes map to 0-3, 7-10 stretches
// - Code zero adds no stretch
// - Codes 1-3 add 1-3 stretches
// - First stretch adds setup and hold
// - Long codes widen latch, setup, hold, strobe
// - Non-page strobe widths 2 to 28 clocks
// - Page enable bit selects page mode
// - Address control written only after unlock
// - Page select sets hit/miss lengths
// - Mode 1 fetch: port zero floats
// - Mode 1 data on port zero
// - Miss when high byte differs
// - Hit drives low byte, no latch
// - Miss: high byte, latch, then hit
// - Select zero forces data-move misses
// - Mode 2: data on port two
// - Two-cycle mode: one-clock fetch strobe
// - Fetch strobe only for external fetches
//
// The implementer's own choice: the APB interface to the registers.
`include "embsp_defs.vh"

module embsp_top (
    input  wire        ref_clk,
    input  wire        rstn,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        req_valid,
    input  wire [1:0]  req_kind,
    input  wire        req_int,
    input  wire [15:0] req_addr,
    input  wire [7:0]  req_wdata,
    output wire        busy,
    output wire        done,
    output wire [7:0]  rdata,
    output wire        addr_latch,
    output wire        code_fetch_strobe_n,
    output wire        rd_n,
    output wire        wr_n,
    output wire [7:0]  port_zero_bus_o,
    output wire        port_zero_bus_oe,
    input  wire [7:0]  port_zero_bus_i,
    output wire [7:0]  port_two_bus_o,
    output wire        port_two_bus_oe,
    input  wire [7:0]  port_two_bus_i
);

    localparam [2:0] PH_IDLE = 3'h0;
    localparam [2:0] PH_ALE  = 3'h1;
    localparam [2:0] PH_SET  = 3'h2;
    localparam [2:0] PH_STB  = 3'h3;
    localparam [2:0] PH_HLD  = 3'h4;
    localparam [2:0] PH_INT  = 3'h5;

    reg [31:0] prdata_q;
    reg        pready_q;
    reg        pslverr_q;
    reg [7:0]  btc_q;
    reg [7:0]  ac_q;
    reg [1:0]  ta_st_q;
    reg [3:0]  ta_cnt_q;
    reg [2:0]  ph_q;
    reg [5:0]  cnt_q;
    reg [5:0]  la_q;
    reg [5:0]  ls_q;
    reg [5:0]  lt_q;
    reg [5:0]  lh_q;
    reg [1:0]  kind_q;
    reg [15:0] addr_q;
    reg [7:0]  wd_q;
    reg [1:0]  bs_q;
    reg        busy_q;
    reg        done_q;
    reg [7:0]  rdata_q;
    reg        ale_q;
    reg        code_fetch_strobe_n_n_q;
    reg        rd_n_q;
    reg        wr_n_q;
    reg [7:0]  p0_o_q;
    reg        p0_oe_q;
    reg [7:0]  p2_o_q;
    reg        p2_oe_q;
    reg [7:0]  p0_m_q;
    reg [7:0]  p0_s_q;
    reg [7:0]  p2_m_q;
    reg [7:0]  p2_s_q;

    wire       page_miss;
    wire       page_valid;
    wire [7:0] last_page;

    assign prdata              = prdata_q;
    assign pready              = pready_q;
    assign pslverr             = pslverr_q;
    assign busy                = busy_q;
    assign done                = done_q;
    assign rdata               = rdata_q;
    assign addr_latch          = ale_q;
    assign code_fetch_strobe_n = code_fetch_strobe_n_n_q;
    assign rd_n                = rd_n_q;
    assign wr_n                = wr_n_q;
    assign port_zero_bus_o     = p0_o_q;
    assign port_zero_bus_oe    = p0_oe_q;
    assign port_two_bus_o      = p2_o_q;
    assign port_two_bus_oe     = p2_oe_q;

    function is_reg;
        input [11:0] a;
        input [9:0]  idx;
        begin
            is_reg = (a[11:2] == idx);
        end
    endfunction

    function [3:0] stretch_cycles;
        input [2:0] code;
        begin
            if (code[2])
                stretch_cycles = `EMBSP_LONG_MIN + {2'h0, code[1:0]};
            else
                stretch_cycles = {2'h0, code[1:0]};
        end
    endfunction

    // Skips latch, setup and hold phases of zero length
    function [2:0] nxt;
        input [2:0] ph;
        input [5:0] a;
        input [5:0] s;
        input [5:0] h;
        begin
            case (ph)
                PH_IDLE: nxt = (a != `EMBSP_ZERO_LEN) ? PH_ALE : (s != `EMBSP_ZERO_LEN) ? PH_SET : PH_STB;
                PH_ALE:  nxt = (s != `EMBSP_ZERO_LEN) ? PH_SET : PH_STB;
                PH_SET:  nxt = PH_STB;
                PH_STB:  nxt = (h != `EMBSP_ZERO_LEN) ? PH_HLD : PH_IDLE;
                default: nxt = PH_IDLE;
            endcase
        end
    endfunction

    function [5:0] len_of;
        input [2:0] ph;
        input [5:0] a;
        input [5:0] s;
        input [5:0] t;
        input [5:0] h;
        begin
            case (ph)
                PH_ALE:  len_of = a;
                PH_SET:  len_of = s;
                PH_STB:  len_of = t;
                PH_HLD:  len_of = h;
                default: len_of = `EMBSP_ONE_LEN;
            endcase
        end
    endfunction

    // Pins cross two flops before use
    always @(posedge ref_clk) begin
        if (!rstn) begin
            p0_m_q <= 8'h00;
            p0_s_q <= 8'h00;
            p2_m_q <= 8'h00;
            p2_s_q <= 8'h00;
        end else if (ce) begin
            p0_m_q <= port_zero_bus_i;
            p0_s_q <= p0_m_q;
            p2_m_q <= port_two_bus_i;
            p2_s_q <= p2_m_q;
        end
    end

    // Register bus slave
    reg [31:0] rd_word;
    reg        hit_reg;
    wire       apb_acc = psel && penable && pready_q;
    wire       ta_open = (ta_st_q == `EMBSP_TA_OPEN);

    always @* begin
        rd_word = 32'h00000000;
        hit_reg = 1'b1;
        if (is_reg(paddr, `EMBSP_RI_BTC))
            rd_word = {24'h000000, btc_q};
        else if (is_reg(paddr, `EMBSP_RI_AC))
            rd_word = {24'h000000, ac_q};
        else if (is_reg(paddr, `EMBSP_RI_TA))
            rd_word = {30'h00000000, ta_st_q};
        else if (is_reg(paddr, `EMBSP_RI_ST))
            rd_word = {16'h0000, last_page, 6'h00, page_valid, busy_q};
        else
            hit_reg = 1'b0;
    end

    always @(posedge ref_clk) begin
        if (!rstn) begin
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            btc_q     <= `EMBSP_BTC_RST;
            ac_q      <= `EMBSP_AC_RST;
            ta_st_q   <= `EMBSP_TA_IDLE;
            ta_cnt_q  <= 4'h0;
        end else if (ce) begin
            // Unlock window closes by itself
            if (ta_open) begin
                if (ta_cnt_q == 4'h0)
                    ta_st_q <= `EMBSP_TA_IDLE;
                else
                    ta_cnt_q <= ta_cnt_q - 4'h1;
            end
            if (psel && !penable) begin
                pready_q  <= 1'b1;
                pslverr_q <= !hit_reg;
                prdata_q  <= rd_word;
            end else if (apb_acc) begin
                pready_q  <= 1'b0;
                pslverr_q <= 1'b0;
            end
            if (apb_acc && pwrite && !pslverr_q) begin
                if (is_reg(paddr, `EMBSP_RI_BTC))
                    btc_q <= pwdata[7:0];
                if (is_reg(paddr, `EMBSP_RI_AC) && ta_open) begin
                    ac_q    <= pwdata[7:0];
                    ta_st_q <= `EMBSP_TA_IDLE;
                end
                if (is_reg(paddr, `EMBSP_RI_TA)) begin
                    if (pwdata[7:0] == `EMBSP_TA_KEY1) begin
                        ta_st_q <= `EMBSP_TA_ARMED;
                    end else if (ta_st_q == `EMBSP_TA_ARMED && pwdata[7:0] == `EMBSP_TA_KEY2) begin
                        ta_st_q  <= `EMBSP_TA_OPEN;
                        ta_cnt_q <= `EMBSP_TA_WIN;
                    end else begin
                        ta_st_q <= `EMBSP_TA_IDLE;
                    end
                end else if (ta_st_q == `EMBSP_TA_ARMED) begin
                    ta_st_q <= `EMBSP_TA_IDLE;
                end
            end
        end
    end

    // Cycle shaping for a new request
    wire       pe      = ac_q[`EMBSP_AC_PGEN];
    wire [1:0] ps      = ac_q[`EMBSP_AC_PGSEL];
    wire       is_data = (req_kind != `EMBSP_K_FETCH);
    wire       idle    = (ph_q == PH_IDLE);
    wire       take    = req_valid && idle;
    wire       take_ex = ce && take && !req_int;
    wire       np_time = !pe || (ps == `EMBSP_PS_MODE2 && is_data);

    reg [3:0] s_cyc;
    reg [5:0] hit_len;
    reg [5:0] l_a;
    reg [5:0] l_s;
    reg [5:0] l_t;
    reg [5:0] l_h;
    reg [1:0] bs_n;

    always @* begin
        s_cyc   = is_data ? stretch_cycles(btc_q[`EMBSP_BTC_STR]) : 4'h0;
        hit_len = `EMBSP_HIT_PS0;
        l_a     = `EMBSP_NP_ALE;
        l_s     = `EMBSP_NP_SET0;
        l_t     = `EMBSP_NP_STB0;
        l_h     = `EMBSP_ZERO_LEN;
        bs_n    = `EMBSP_BS_NP;
        if (np_time) begin
            // Mode 2 data keeps classic timing
            bs_n = pe ? `EMBSP_BS_PM2 : `EMBSP_BS_NP;
            if (s_cyc == 4'h0) begin
                l_t = `EMBSP_NP_STB0;
            end else if (s_cyc < `EMBSP_LONG_MIN) begin
                // Two clock setup, one clock hold
                l_s = `EMBSP_NP_SET1;
                l_t = `EMBSP_STR_CLKS * {2'h0, s_cyc};
                l_h = `EMBSP_NP_HLD1;
            end else begin
                l_a = `EMBSP_LONG_ALE;
                l_s = `EMBSP_LONG_SET;
                l_t = `EMBSP_STR_CLKS * {2'h0, s_cyc - `EMBSP_LONG_BASE};
                l_h = `EMBSP_LONG_HLD;
            end
        end else begin
            bs_n = (ps == `EMBSP_PS_MODE2) ? `EMBSP_BS_PM2 : `EMBSP_BS_PM1;
            case (ps)
                `EMBSP_PS_1CYC: begin
                    hit_len = `EMBSP_HIT_PS0;
                    l_t     = `EMBSP_HSTB_PS0;
                end
                `EMBSP_PS_2CYC: begin
                    hit_len = `EMBSP_HIT_PS1;
                    l_t     = `EMBSP_HSTB_PS1;
                end
                `EMBSP_PS_4CYC: begin
                    hit_len = `EMBSP_HIT_PS2;
                    l_t     = `EMBSP_HSTB_PS2;
                end
                default: begin
                    hit_len = `EMBSP_HIT_M2;
                    l_t     = `EMBSP_HSTB_M2;
                end
            endcase
            // Miss doubles with a latch half
            l_a = page_miss ? hit_len : `EMBSP_ZERO_LEN;
            l_s = hit_len - l_t;
        end
    end

    embsp_page_det u_page_det (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .ce         (ce),
        .pg_en      (pe),
        .pg_sel     (ps),
        .take       (take_ex),
        .is_data    (is_data),
        .addr_hi    (req_addr[15:8]),
        .miss       (page_miss),
        .page_valid (page_valid),
        .last_page  (last_page)
    );

    // Phase sequencer
    reg [2:0] ph_d;
    reg [5:0] cnt_d;
    reg       done_d;

    always @* begin
        ph_d   = ph_q;
        cnt_d  = cnt_q;
        done_d = 1'b0;
        if (idle) begin
            if (req_valid) begin
                if (req_int) begin
                    ph_d  = PH_INT;
                    cnt_d = `EMBSP_ZERO_LEN;
                end else begin
                    ph_d  = nxt(PH_IDLE, l_a, l_s, l_h);
                    cnt_d = len_of(ph_d, l_a, l_s, l_t, l_h) - `EMBSP_ONE_LEN;
                end
            end
        end else if (ph_q == PH_INT) begin
            ph_d   = PH_IDLE;
            done_d = 1'b1;
        end else if (cnt_q != `EMBSP_ZERO_LEN) begin
            cnt_d = cnt_q - `EMBSP_ONE_LEN;
        end else begin
            ph_d   = nxt(ph_q, la_q, ls_q, lh_q);
            cnt_d  = len_of(ph_d, la_q, ls_q, lt_q, lh_q) - `EMBSP_ONE_LEN;
            done_d = (ph_d == PH_IDLE);
        end
    end

    // Pin values follow the next phase
    wire [1:0]  kind_c = idle ? req_kind : kind_q;
    wire [15:0] addr_c = idle ? req_addr : addr_q;
    wire [7:0]  wd_c   = idle ? req_wdata : wd_q;
    wire [1:0]  bs_c   = idle ? bs_n : bs_q;
    wire        wr_c   = (kind_c == `EMBSP_K_WR);

    reg       ale_d;
    reg       code_fetch_strobe_n_n_d;
    reg       rd_n_d;
    reg       wr_n_d;
    reg [7:0] p0_o_d;
    reg       p0_oe_d;
    reg [7:0] p2_o_d;
    reg       p2_oe_d;

    always @* begin
        ale_d    = 1'b0;
        code_fetch_strobe_n_n_d = 1'b1;
        rd_n_d   = 1'b1;
        wr_n_d   = 1'b1;
        p0_o_d   = 8'h00;
        p0_oe_d  = 1'b0;
        p2_o_d   = 8'h00;
        p2_oe_d  = 1'b0;
        if (ph_d == PH_ALE) begin
            ale_d   = 1'b1;
            p2_o_d  = addr_c[15:8];
            p2_oe_d = 1'b1;
            if (bs_c != `EMBSP_BS_PM1) begin
                p0_o_d  = addr_c[7:0];
                p0_oe_d = 1'b1;
            end
        end else if (ph_d == PH_SET || ph_d == PH_STB || ph_d == PH_HLD) begin
            case (bs_c)
                `EMBSP_BS_PM1: begin
                    p2_o_d  = addr_c[7:0];
                    p2_oe_d = 1'b1;
                    p0_o_d  = wd_c;
                    p0_oe_d = wr_c;
                end
                `EMBSP_BS_PM2: begin
                    // Low byte on zero, data on two
                    p0_o_d  = addr_c[7:0];
                    p0_oe_d = 1'b1;
                    p2_o_d  = wd_c;
                    p2_oe_d = wr_c;
                end
                default: begin
                    p2_o_d  = addr_c[15:8];
                    p2_oe_d = 1'b1;
                    p0_o_d  = wd_c;
                    p0_oe_d = wr_c;
                end
            endcase
            if (ph_d == PH_STB) begin
                code_fetch_strobe_n_n_d = (kind_c != `EMBSP_K_FETCH);
                rd_n_d   = (kind_c != `EMBSP_K_RD);
                wr_n_d   = !wr_c;
            end
        end
    end

    always @(posedge ref_clk) begin
        if (!rstn) begin
            ph_q     <= PH_IDLE;
            cnt_q    <= `EMBSP_ZERO_LEN;
            la_q     <= `EMBSP_ZERO_LEN;
            ls_q     <= `EMBSP_ZERO_LEN;
            lt_q     <= `EMBSP_ZERO_LEN;
            lh_q     <= `EMBSP_ZERO_LEN;
            kind_q   <= `EMBSP_K_FETCH;
            addr_q   <= 16'h0000;
            wd_q     <= 8'h00;
            bs_q     <= `EMBSP_BS_NP;
            busy_q   <= 1'b0;
            done_q   <= 1'b0;
            rdata_q  <= 8'h00;
            ale_q    <= 1'b0;
            code_fetch_strobe_n_n_q <= 1'b1;
            rd_n_q   <= 1'b1;
            wr_n_q   <= 1'b1;
            p0_o_q   <= 8'h00;
            p0_oe_q  <= 1'b0;
            p2_o_q   <= 8'h00;
            p2_oe_q  <= 1'b0;
        end else if (ce) begin
            ph_q   <= ph_d;
            cnt_q  <= cnt_d;
            busy_q <= (ph_d != PH_IDLE);
            done_q <= done_d;
            if (take) begin
                la_q   <= l_a;
                ls_q   <= l_s;
                lt_q   <= l_t;
                lh_q   <= l_h;
                kind_q <= req_kind;
                addr_q <= req_addr;
                wd_q   <= req_wdata;
                bs_q   <= bs_n;
            end
            // Data taken as the strobe ends
            if (ph_q == PH_STB && cnt_q == `EMBSP_ZERO_LEN && kind_q != `EMBSP_K_WR)
                rdata_q <= (bs_q == `EMBSP_BS_PM2) ? p2_s_q : p0_s_q;
            ale_q    <= ale_d;
            code_fetch_strobe_n_n_q <= code_fetch_strobe_n_n_d;
            rd_n_q   <= rd_n_d;
            wr_n_q   <= wr_n_d;
            p0_o_q   <= p0_o_d;
            p0_oe_q  <= p0_oe_d;
            p2_o_q   <= p2_o_d;
            p2_oe_q  <= p2_oe_d;
        end
    end

endmodule // embsp_top

// ==== verification/embsp_assertions.sv ====
// Port checker for the external memory bus sequencer
module embsp_assertions (
    input wire ref_clk,
    input wire rstn,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire req_valid,
    input wire req_int,
    input wire busy,
    input wire done,
    input wire addr_latch,
    input wire code_fetch_strobe_n,
    input wire rd_n,
    input wire wr_n,
    input wire port_two_bus_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    wire strb = !rd_n || !wr_n || !code_fetch_strobe_n;
    sequence s_take_int;
        ce && req_valid && req_int && !busy;
    endsequence
    sequence s_quiet_done;
        done && !busy && !addr_latch && !strb;
    endsequence
    a_int_one_clock: assert property (s_take_int |=> busy ##1 s_quiet_done)
        else $error("internal access not finished in one clock");
    a_take_ext_busy: assert property (ce && req_valid && !req_int && !busy |=> busy && !done)
        else $error("external access not held busy");
    a_busy_ends_done: assert property ($fell(busy) |-> done)
        else $error("busy dropped without done");
    a_latch_no_strobe: assert property (addr_latch |-> !strb)
        else $error("strobe active during address latch");
    a_latch_drives_hi: assert property (addr_latch |-> port_two_bus_oe)
        else $error("port two not driven during address latch");
    a_one_strobe: assert property ($onehot0({!rd_n, !wr_n, !code_fetch_strobe_n}))
        else $error("more than one strobe active");
    a_idle_pins: assert property (!busy |-> !strb && !addr_latch)
        else $error("strobe or latch active while idle");
    a_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("register access not answered in one cycle");
endmodule // embsp_assertions

bind embsp_top embsp_assertions u_chk (.*);

// ==== verification/embsp_mem_model.sv ====
// External memory with an address latch on port two
module embsp_mem_model (
    input  wire       ref_clk,
    input  wire       addr_latch,
    input  wire       code_fetch_strobe_n,
    input  wire       rd_n,
    input  wire [7:0] port_two_bus_o,
    output wire [7:0] port_zero_bus_i,
    output wire [7:0] port_two_bus_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] hi_q = 8'h00;
    wire        drv  = !rd_n || !code_fetch_strobe_n;
    wire  [7:0] dat  = hi_q ^ 8'h5A;
    always @(posedge ref_clk) begin
        if (addr_latch) begin
            hi_q <= port_two_bus_o;
        end
    end
    // Released bus shows the inverse, never a stale value
    assign port_zero_bus_i = drv ? dat : ~dat;
    assign port_two_bus_i  = drv ? dat : ~dat;
endmodule // embsp_mem_model

// ==== verification/tb_ext_mem_bus_stretch_page.sv ====
// Testbench for the external memory bus sequencer
`include "embsp_defs.vh"
module tb_ext_mem_bus_stretch_page;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] adr_btc = {`EMBSP_RI_BTC, 2'b00};
    localparam logic [11:0] adr_ac  = {`EMBSP_RI_AC, 2'b00};
    localparam logic [11:0] adr_ta  = {`EMBSP_RI_TA, 2'b00};
    localparam logic [1:0]  k_f     = `EMBSP_K_FETCH;
    localparam logic [1:0]  k_r     = `EMBSP_K_RD;
    localparam logic [1:0]  k_w     = `EMBSP_K_WR;
    logic        ref_clk, rstn, ce, psel, penable, pwrite, req_valid, req_int, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic [1:0]  req_kind;
    logic [15:0] req_addr;
    logic [7:0]  req_wdata, hi_seen, wd_seen;
    wire  [31:0] prdata;
    wire         pready, pslverr, busy, done, addr_latch, code_fetch_strobe_n, rd_n, wr_n;
    wire         port_zero_bus_oe, port_two_bus_oe;
    wire  [7:0]  rdata, port_zero_bus_o, port_two_bus_o, port_zero_bus_i, port_two_bus_i;
    int          n_errors, checks, len, stb, ale, zoe;

    embsp_top dut (.*);
    embsp_mem_model u_mem (.*);

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        if (n_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge ref_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic ac_wr(logic [7:0] v);
        apb(1'b1, adr_ta, {24'h0, `EMBSP_TA_KEY1});
        apb(1'b1, adr_ta, {24'h0, `EMBSP_TA_KEY2});
        apb(1'b1, adr_ac, {24'h0, v});
    endtask

    // Counts clocks from take to done, sampling settled pins
    task automatic req(logic [1:0] k, logic i, logic [15:0] a);
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req_kind  <= k;
        req_int   <= i;
        req_addr  <= a;
        @(posedge ref_clk);
        req_valid <= 1'b0;
        len = 0;
        stb = 0;
        ale = 0;
        zoe = 0;
        while (len < 100) begin
            #1;
            if (done === 1'b1) break;
            len++;
            if (!rd_n || !wr_n || !code_fetch_strobe_n) stb++;
            if (addr_latch) begin
                ale++;
                hi_seen = port_two_bus_o;
            end
            if (port_zero_bus_oe) begin
                zoe++;
                wd_seen = port_zero_bus_o;
            end
            @(posedge ref_clk);
        end
    endtask

    task automatic rq(logic [1:0] k, logic [15:0] a, int el, int ea);
        req(k, 1'b0, a);
        chk("cycle length", len, el);
        chk("latch clocks", ale, ea);
    endtask

    task automatic t_regs();
        apb(1'b0, adr_btc, 0);
        chk("timing reset", rd[7:0], `EMBSP_BTC_RST);
        apb(1'b1, adr_ac, 32'h81);
        apb(1'b0, adr_ac, 0);
        chk("locked page ctrl", rd[7:0], 8'h00);
        apb(1'b0, 12'hFFC, 0);
        chk("unmapped error", err, 1'b1);
    endtask

    task automatic t_stretch();
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, adr_btc, c);
            rq(k_r, 16'h4300 + c, c < 4 ? 4 + 4 * c : 16 + 4 * c, c < 4 ? 1 : 5);
            chk("strobe clocks", stb, c == 0 ? 2 : 4 * c);
            chk("latched page", hi_seen, 8'h43);
        end
        chk("read data", rdata, 8'h43 ^ 8'h5A);
        apb(1'b1, adr_btc, 1);
        rq(k_w, 16'h4400, 8, 1);
        chk("write strobe", stb, 4);
        rq(k_f, 16'h4401, 4, 1);
        req(k_f, 1'b1, 16'h0010);
        chk("internal length", len, 1);
        chk("internal strobe", stb, 0);
    endtask

    task automatic t_page1();
        ac_wr(8'h81);
        apb(1'b0, adr_ac, 0);
        chk("page ctrl", rd[7:0], 8'h81);
        rq(k_f, 16'h1234, 4, 2);
        chk("latched page", hi_seen, 8'h12);
        chk("fetch bus float", zoe, 0);
        rq(k_f, 16'h1256, 2, 0);
        chk("fetch strobe", stb, 1);
        rq(k_f, 16'h1310, 4, 2);
        rq(k_r, 16'h1320, 2, 0);
        chk("read bus float", zoe, 0);
        rq(k_w, 16'h1322, 2, 0);
        chk("write bus driven", zoe > 0, 1);
        chk("write data", wd_seen, 8'hC3);
    endtask

    task automatic t_page0();
        ac_wr(8'h80);
        rq(k_f, 16'h1330, 2, 1);
        rq(k_f, 16'h1331, 1, 0);
        chk("fetch strobe", stb, 1);
        rq(k_r, 16'h1332, 2, 1);
        rq(k_f, 16'h1333, 2, 1);
        rq(k_f, 16'h1334, 1, 0);
        ac_wr(8'h82);
        rq(k_f, 16'h1400, 8, 4);
        rq(k_f, 16'h1401, 4, 0);
        chk("fetch strobe", stb, 2);
    endtask

    task automatic t_page2();
        apb(1'b1, adr_btc, 0);
        ac_wr(8'h83);
        rq(k_f, 16'h2000, 4, 2);
        rq(k_f, 16'h2001, 2, 0);
        rq(k_r, 16'h2002, 4, 1);
        ac_wr(8'h00);
        rq(k_f, 16'h2003, 4, 1);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Whole run needs several hundred clocks
    initial begin
        #200000;
        n_errors++;
        end_sim();
    end

    initial begin
        rstn      = 1'b0;
        ce        = 1'b1;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 12'h000;
        pwdata    = 32'h0;
        req_valid = 1'b0;
        req_int   = 1'b0;
        req_kind  = 2'h0;
        req_addr  = 16'h0;
        req_wdata = 8'hC3;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        t_regs();
        t_stretch();
        t_page1();
        t_page0();
        t_page2();
        end_sim();
    end
endmodule // tb_ext_mem_bus_stretch_page
